// >>> urs_params.svh
// Purpose: Constants for the receive status block
// Assumes: 50 MHz core clock
// Notes: Offsets are byte addresses on the register bus
`ifndef URS_PARAMS_SVH
`define URS_PARAMS_SVH
`define URS_OFS_STATUS 8'h00
`define URS_OFS_CONFIG 8'h04
`define URS_OFS_DATA 8'h08
`define URS_OFS_IRQ_STAT 8'h0c
`define URS_OFS_IRQ_MASK 8'h10
`define URS_BIT_ADDRESS_DETECT_ENABLE 5
`define URS_BIT_IDLE 4
`define URS_BIT_PARITY_ERROR_FLAG 3
`define URS_BIT_FRAMING_ERROR_FLAG 2
`define URS_BIT_OVR 1
`define URS_BIT_AVAIL 0
`define URS_CFG_NINE 0
`define URS_CFG_PAREN 1
`define URS_CFG_PARODD 2
`define URS_CFG_RXEN 3
`define URS_CFG_RESET 4'h0
`define URS_DIV_DEFAULT 16'h01b2
`define URS_FIFO_DEPTH 4
`define URS_PTR_W 2
`define URS_BITS_NINE 4'h9
`define URS_BITS_EIGHT 4'h8
`define URS_IRQ_AVAIL 0
`define URS_IRQ_OVR 1
`define URS_IRQ_ERR 2
`define URS_IRQ_ADDR 3
`endif

// >>> urs_pkg.sv
// Purpose: Types for the receive status block
// Assumes: Included constants header
// Notes: None
package urs_pkg;
   typedef struct packed {
      logic [8:0] data;
      logic parityErr;
      logic frameErr;
   } urs_entry_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
      RX_STOP} urs_state_t;
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic sel;
   } urs_req_t;
endpackage : urs_pkg

// >>> urs_receive_status.sv
// Purpose: Serial receiver with status, FIFO and AHB-Lite registers
// Assumes: Single clock, rx line synchronous to core_clk
// Notes: Overrun blocks reception until cleared
`timescale 1ns/100ps
`include "urs_params.svh"
module urs_receive_status (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rxLine,
   output logic irq
);
   import urs_pkg::*;

   // ----------------------------------------------------------------
   // Bus and register state
   // ----------------------------------------------------------------
   urs_req_t req_q, req_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [3:0] cfg_q, cfg_d;
   logic addrDetectEn_q, addrDetectEn_d;
   logic overrun_q, overrun_d;
   logic [3:0] irqStat_q, irqStat_d;
   logic [3:0] irqMask_q, irqMask_d;
   logic irq_q, irq_d;
   logic [15:0] divisor_q, divisor_d;

   // ----------------------------------------------------------------
   // Receiver and FIFO state
   // ----------------------------------------------------------------
   urs_state_t state_q, state_d;
   logic [15:0] baudCnt_q, baudCnt_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [8:0] shiftReg_q, shiftReg_d;
   logic parAcc_q, parAcc_d;
   logic parErr_q, parErr_d;
   logic rxPrev_q, rxPrev_d;
   urs_entry_t fifo_q [`URS_FIFO_DEPTH];
   urs_entry_t fifo_d [`URS_FIFO_DEPTH];
   logic [`URS_PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [`URS_PTR_W:0] count_q, count_d;

   function automatic logic isAddr(input logic [7:0] a, input logic [7:0] o);
      isAddr = (a == o);
   endfunction : isAddr

   logic wrAcc, rdAcc, ovrClear, pushReq, pushOk, pop, empty, full;
   logic dataWr, cfgWr, stWr, imWr, smWr;
   logic [3:0] dataBits;
   urs_entry_t newEntry, head;
   logic [15:0] halfDiv;

   always_comb
   begin
      empty = (count_q == '0);
      full = (count_q == (`URS_PTR_W+1)'(`URS_FIFO_DEPTH));
      head = fifo_q[rdPtr_q];
      wrAcc = req_q.sel && req_q.write;
      rdAcc = hsel && hready && htrans[1] && !hwrite;
      stWr = wrAcc && isAddr(req_q.addr[7:0], `URS_OFS_STATUS);
      cfgWr = wrAcc && isAddr(req_q.addr[7:0], `URS_OFS_CONFIG);
      dataWr = wrAcc && isAddr(req_q.addr[7:0], `URS_OFS_DATA);
      smWr = wrAcc && isAddr(req_q.addr[7:0], `URS_OFS_IRQ_STAT);
      imWr = wrAcc && isAddr(req_q.addr[7:0], `URS_OFS_IRQ_MASK);
      // Clearing overrun only acts on a 1 to 0 transition
      ovrClear = stWr && overrun_q && !hwdata[`URS_BIT_OVR];
      pop = rdAcc && isAddr(haddr[7:0], `URS_OFS_DATA) && !empty;
      dataBits = cfg_q[`URS_CFG_NINE] ? `URS_BITS_NINE : `URS_BITS_EIGHT;
      halfDiv = {1'b0, divisor_q[15:1]};
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   always_comb
   begin
      req_d.sel = hsel && hready && htrans[1];
      req_d.write = hwrite;
      req_d.addr = haddr;
      hrdata_d = hrdata_q;
      cfg_d = cfg_q;
      addrDetectEn_d = addrDetectEn_q;
      irqMask_d = irqMask_q;
      divisor_d = divisor_q;
      if (stWr)
      begin
         addrDetectEn_d = hwdata[`URS_BIT_ADDRESS_DETECT_ENABLE];
      end
      if (cfgWr)
      begin
         cfg_d = hwdata[3:0];
         divisor_d = hwdata[31:16];
      end
      if (imWr)
      begin
         irqMask_d = hwdata[3:0];
      end
      if (rdAcc)
      begin
         hrdata_d = '0;
         case (haddr[7:0])
            `URS_OFS_STATUS:
            begin
               hrdata_d[`URS_BIT_ADDRESS_DETECT_ENABLE] = addrDetectEn_q;
               hrdata_d[`URS_BIT_IDLE] = (state_q == RX_IDLE);
               hrdata_d[`URS_BIT_PARITY_ERROR_FLAG] = !empty && head.parityErr;
               hrdata_d[`URS_BIT_FRAMING_ERROR_FLAG] = !empty && head.frameErr;
               hrdata_d[`URS_BIT_OVR] = overrun_q;
               hrdata_d[`URS_BIT_AVAIL] = !empty;
            end
            `URS_OFS_CONFIG: hrdata_d = {divisor_q, 12'h000, cfg_q};
            `URS_OFS_DATA: hrdata_d[8:0] = empty ? 9'h000 : head.data;
            `URS_OFS_IRQ_STAT: hrdata_d[3:0] = irqStat_q;
            `URS_OFS_IRQ_MASK: hrdata_d[3:0] = irqMask_q;
            default: hrdata_d = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      baudCnt_d = baudCnt_q;
      bitCnt_d = bitCnt_q;
      shiftReg_d = shiftReg_q;
      parAcc_d = parAcc_q;
      parErr_d = parErr_q;
      rxPrev_d = rxLine;
      pushReq = 1'b0;
      newEntry = '0;
      if (baudCnt_q != '0)
      begin
         baudCnt_d = baudCnt_q - 16'h0001;
      end
      case (state_q)
         RX_IDLE:
         begin
            // Blocked while overrun stands
            if (cfg_q[`URS_CFG_RXEN] && !overrun_q && rxPrev_q && !rxLine)
            begin
               state_d = RX_START;
               baudCnt_d = halfDiv;
            end
         end
         RX_START:
         begin
            if (baudCnt_q == '0)
            begin
               state_d = rxLine ? RX_IDLE : RX_DATA;
               baudCnt_d = divisor_q - 16'h0001;
               bitCnt_d = '0;
               shiftReg_d = '0;
               parAcc_d = cfg_q[`URS_CFG_PARODD];
               parErr_d = 1'b0;
            end
         end
         RX_DATA:
         begin
            if (baudCnt_q == '0)
            begin
               shiftReg_d[bitCnt_q] = rxLine;
               parAcc_d = parAcc_q ^ rxLine;
               bitCnt_d = bitCnt_q + 4'h1;
               baudCnt_d = divisor_q - 16'h0001;
               if (bitCnt_q == dataBits - 4'h1)
               begin
                  state_d = cfg_q[`URS_CFG_PAREN] ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR:
         begin
            if (baudCnt_q == '0)
            begin
               parErr_d = parAcc_q ^ rxLine;
               baudCnt_d = divisor_q - 16'h0001;
               state_d = RX_STOP;
            end
         end
         RX_STOP:
         begin
            if (baudCnt_q == '0)
            begin
               pushReq = 1'b1;
               newEntry.data = shiftReg_q;
               newEntry.parityErr = parErr_q;
               newEntry.frameErr = !rxLine;
               state_d = RX_IDLE;
            end
         end
         default: state_d = RX_IDLE;
      endcase
      if (ovrClear)
      begin
         state_d = RX_IDLE;
         shiftReg_d = '0;
      end
   end

   // ----------------------------------------------------------------
   // FIFO, overrun and interrupts
   // ----------------------------------------------------------------
   always_comb
   begin
      fifo_d = fifo_q;
      wrPtr_d = wrPtr_q;
      rdPtr_d = rdPtr_q;
      count_d = count_q;
      overrun_d = overrun_q;
      irqStat_d = irqStat_q;
      pushOk = pushReq && !full;
      if (pushOk)
      begin
         fifo_d[wrPtr_q] = newEntry;
         wrPtr_d = wrPtr_q + 1'b1;
      end
      if (pop)
      begin
         rdPtr_d = rdPtr_q + 1'b1;
      end
      count_d = count_q + (pushOk ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      if (ovrClear)
      begin
         overrun_d = 1'b0;
         wrPtr_d = '0;
         rdPtr_d = '0;
         count_d = '0;
      end
      if (pushReq && full)
      begin
         overrun_d = 1'b1;
      end
      if (smWr)
      begin
         irqStat_d = irqStat_q & ~hwdata[3:0];
      end
      // Events set after the clear so a set wins
      if (pushOk)
      begin
         irqStat_d[`URS_IRQ_AVAIL] = 1'b1;
      end
      if (pushReq && full)
      begin
         irqStat_d[`URS_IRQ_OVR] = 1'b1;
      end
      if (pushOk && (newEntry.parityErr || newEntry.frameErr))
      begin
         irqStat_d[`URS_IRQ_ERR] = 1'b1;
      end
      if (pushOk && addrDetectEn_q && cfg_q[`URS_CFG_NINE] &&
         newEntry.data[8])
      begin
         irqStat_d[`URS_IRQ_ADDR] = 1'b1;
      end
      irq_d = |(irqStat_d & irqMask_q);
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         req_q <= '0;
         hrdata_q <= '0;
         cfg_q <= `URS_CFG_RESET;
         addrDetectEn_q <= 1'b0;
         overrun_q <= 1'b0;
         irqStat_q <= '0;
         irqMask_q <= '0;
         irq_q <= 1'b0;
         divisor_q <= `URS_DIV_DEFAULT;
         state_q <= RX_IDLE;
         baudCnt_q <= '0;
         bitCnt_q <= '0;
         shiftReg_q <= '0;
         parAcc_q <= 1'b0;
         parErr_q <= 1'b0;
         rxPrev_q <= 1'b1;
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         for (int i = 0; i < `URS_FIFO_DEPTH; i++)
         begin
            fifo_q[i] <= '0;
         end
      end
      else
      begin
         req_q <= req_d;
         hrdata_q <= hrdata_d;
         cfg_q <= cfg_d;
         addrDetectEn_q <= addrDetectEn_d;
         overrun_q <= overrun_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         irq_q <= irq_d;
         divisor_q <= divisor_d;
         state_q <= state_d;
         baudCnt_q <= baudCnt_d;
         bitCnt_q <= bitCnt_d;
         shiftReg_q <= shiftReg_d;
         parAcc_q <= parAcc_d;
         parErr_q <= parErr_d;
         rxPrev_q <= rxPrev_d;
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
         fifo_q <= fifo_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      hrdata = hrdata_q;
      hreadyout = 1'b1;
      hresp = 1'b0;
      irq = irq_q;
   end
endmodule : urs_receive_status

// >>> urs_receive_status_properties.sv
// Purpose: Port assertions for the receive status block
// Assumes: Status at 0x00, data at 0x08
// Notes: Status bits are seen through bus reads
`timescale 1ns/100ps
module urs_receive_status_properties (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic rxLine,
   input wire logic irq
);
   logic stA, dA, stRd_q, stWr_q, seen_q, ovr_q, clr_q;
   assign stA = hsel && hready && htrans[1] && haddr == 32'h0;
   assign dA = hsel && hready && htrans[1] && haddr == 32'h8;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stRd_q <= 1'h0;
         stWr_q <= 1'h0;
         seen_q <= 1'h0;
         ovr_q <= 1'h0;
         clr_q <= 1'h0;
      end
      else
      begin
         stRd_q <= stA && !hwrite;
         stWr_q <= stA && hwrite;
         seen_q <= seen_q || !rxLine;
         if (stRd_q)
            ovr_q <= hrdata[1];
         if (stWr_q && !hwdata[1] && ovr_q)
            clr_q <= 1'h1;
         else if (stRd_q || !rxLine)
            clr_q <= 1'h0;
      end
   end
   // ---
   // Checks
   // ---
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   idle_quiet_a: assert property (stRd_q && !seen_q |-> hrdata[4])
      else $error("idle bit low without traffic");
   ovr_noset_a: assert property (stRd_q && !seen_q |-> !hrdata[1])
      else $error("overrun set without traffic");
   avail_empty_a: assert property (dA && !hwrite && !seen_q |=>
      hrdata == 32'h0) else $error("empty data read not zero");
   irq_cause_a: assert property ($rose(irq) |-> seen_q)
      else $error("irq without received character");
   parity_head_a: assert property (stRd_q && hrdata[3] |-> hrdata[0])
      else $error("parity flag with empty fifo");
   frame_head_a: assert property (stRd_q && hrdata[2] |-> hrdata[0])
      else $error("framing flag with empty fifo");
   ovr_block_a: assert property (stRd_q && hrdata[1] |-> hrdata[4])
      else $error("receiver busy while overrun stands");
   ovr_flush_a: assert property (stRd_q && clr_q |-> !hrdata[1:0])
      else $error("fifo not flushed by overrun clear");
   cover property (stRd_q && hrdata[1]);
   cover property (stRd_q && !hrdata[4]);
   cover property ($rose(irq));
endmodule : urs_receive_status_properties
bind urs_receive_status urs_receive_status_properties
   urs_receive_status_properties_i (.core_clk(core_clk), .sys_rst(sys_rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .rxLine(rxLine),
   .irq(irq));

// >>> urs_serial_tx.sv
// Purpose: Far-end serial transmitter on the receive line
// Assumes: Bit period of DIV core clocks
// Notes: Line idles high between frames
`timescale 1ns/100ps
module urs_serial_tx #(
   parameter int DIV = 16
) (
   input wire logic core_clk,
   output logic rxLine
);
   initial rxLine = 1'h1;
   task automatic bitOut(input logic b);
      rxLine <= b;
      repeat (DIV) @(posedge core_clk);
   endtask : bitOut
   task automatic sendChar(input logic [8:0] d, input int nb,
      input logic pe, input logic pb, input logic sb);
      @(posedge core_clk);
      bitOut(1'h0);
      for (int i = 0; i < nb; i++)
         bitOut(d[i]);
      if (pe)
         bitOut(pb);
      bitOut(sb);
      rxLine <= 1'h1;
   endtask : sendChar
endmodule : urs_serial_tx

// >>> urs_receive_status_tb_top.sv
// Purpose: Self-checking bench for the receive status block
// Assumes: Bit period shortened to DIV clocks
// Notes: Single AHB-Lite transfers only
`timescale 1ns/100ps
`include "urs_params.svh"
module urs_receive_status_tb_top;
   import urs_pkg::*;
   localparam int DIV = 16;
   logic core_clk, sys_rst, hsel, hwrite, hready, hresp, rxLine, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [9:0] cs [3];
   int num_errors = 0;
   int n_tests = 0;
   urs_receive_status urs_receive_status_i (.core_clk(core_clk),
      .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .rxLine(rxLine), .irq(irq));
   urs_serial_tx #(.DIV(DIV)) urs_serial_tx_i (.core_clk(core_clk),
      .rxLine(rxLine));
   initial
   begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic summarize;
      $display("errors %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic acc(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge core_clk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'h1);
      rd = hrdata;
   endtask : acc
   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      acc(a, 1'h0, 32'h0);
      chk(nm, e, rd);
   endtask : rchk
   task automatic send(input logic [8:0] d, input int nb,
      input logic pe, input logic pb, input logic sb);
      urs_serial_tx_i.sendChar(d, nb, pe, pb, sb);
      repeat (8) @(posedge core_clk);
   endtask : send
   function automatic logic [31:0] cfg(input logic [3:0] m);
      return {16'(DIV), 12'h0, m};
   endfunction : cfg
   initial
   begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      $display("CHECK FAILED watchdog expected done seen hang");
      summarize();
   end
   initial
   begin
      sys_rst = 1'h1;
      hsel = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      cs[0] = 10'h3a5;
      cs[1] = 10'h2a5;
      cs[2] = 10'h0ff;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'h0;
      rchk("status", `URS_OFS_STATUS, 32'h10);
      chk("hresp", 32'h0, {31'h0, hresp});
      rchk("config", `URS_OFS_CONFIG, 32'h01b20000);
      rchk("data", `URS_OFS_DATA, 32'h0);
      acc(`URS_OFS_STATUS, 1'h1, 32'h2);
      rchk("status", `URS_OFS_STATUS, 32'h10);
      rchk("unmapped", 8'h14, 32'h0);
      acc(`URS_OFS_IRQ_MASK, 1'h1, 32'hf);
      acc(`URS_OFS_CONFIG, 1'h1, cfg(4'ha));
      fork
         send(9'h55, 8, 1'h1, 1'h0, 1'h1);
         begin
            repeat (80) @(posedge core_clk);
            rchk("busy", `URS_OFS_STATUS, 32'h0);
         end
      join
      chk("irq", 32'h1, {31'h0, irq});
      rchk("status", `URS_OFS_STATUS, 32'h11);
      send(9'haa, 8, 1'h1, 1'h1, 1'h0);
      rchk("status", `URS_OFS_STATUS, 32'h11);
      rchk("data", `URS_OFS_DATA, 32'h55);
      rchk("status", `URS_OFS_STATUS, 32'h1d);
      rchk("data", `URS_OFS_DATA, 32'haa);
      rchk("irqstat", `URS_OFS_IRQ_STAT, 32'h5);
      acc(`URS_OFS_IRQ_STAT, 1'h1, 32'hf);
      rchk("irqstat", `URS_OFS_IRQ_STAT, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      for (int i = 0; i < 6; i++)
         send(9'h30 + 9'(i), 8, 1'h1, ^(8'h30 + 8'(i)), 1'h1);
      rchk("status", `URS_OFS_STATUS, 32'h13);
      acc(`URS_OFS_STATUS, 1'h1, 32'h0);
      rchk("status", `URS_OFS_STATUS, 32'h10);
      rchk("data", `URS_OFS_DATA, 32'h0);
      acc(`URS_OFS_IRQ_STAT, 1'h1, 32'hf);
      acc(`URS_OFS_STATUS, 1'h1, 32'h20);
      rchk("status", `URS_OFS_STATUS, 32'h30);
      for (int i = 0; i < 3; i++)
      begin
         acc(`URS_OFS_CONFIG, 1'h1, cfg({3'h4, cs[i][9]}));
         send(cs[i][8:0], cs[i][9] ? 9 : 8, 1'h0, 1'h0, 1'h1);
         rchk("irqstat", `URS_OFS_IRQ_STAT,
            {28'h0, cs[i][9] & cs[i][8], 3'h1});
         rchk("data", `URS_OFS_DATA, {23'h0, cs[i][8:0]});
         acc(`URS_OFS_IRQ_STAT, 1'h1, 32'hf);
      end
      acc(`URS_OFS_CONFIG, 1'h1, cfg(4'he));
      send(9'h0f, 8, 1'h1, 1'h1, 1'h1);
      send(9'h0f, 8, 1'h1, 1'h0, 1'h1);
      rchk("status", `URS_OFS_STATUS, 32'h31);
      rchk("data", `URS_OFS_DATA, 32'h0f);
      rchk("status", `URS_OFS_STATUS, 32'h39);
      rchk("data", `URS_OFS_DATA, 32'h0f);
      summarize();
   end
endmodule : urs_receive_status_tb_top
